// ===== rtl/pmr_defines.vh
// constants for the power monitor manufacturer command register set
`ifndef PMR_DEFINES_VH
`define PMR_DEFINES_VH

// ----------------------------------------------------------------
// command codes
// ----------------------------------------------------------------
`define PMR_CMD_CLEAR_FAULTS 8'h03
`define PMR_CMD_AUX_VOLT 8'hD0
`define PMR_CMD_IN_CURR 8'hD1
`define PMR_CMD_IN_POWER 8'hD2
`define PMR_CMD_OC_LIMIT 8'hD3
`define PMR_CMD_OP_LIMIT 8'hD4
`define PMR_CMD_PEAK_POWER 8'hD5
`define PMR_CMD_PEAK_CLEAR 8'hD6
`define PMR_CMD_ALERT_MASK 8'hD8
`define PMR_CMD_GAIN_SETUP 8'hD9

// ----------------------------------------------------------------
// reset values and codes
// ----------------------------------------------------------------
`define PMR_RST_READING 12'h000
`define PMR_RST_LIMIT 12'hFFF
`define PMR_LIMIT_OFF 12'hFFF
`define PMR_AUX_FULL 12'hFFF
`define PMR_RST_MASK 16'h0000
`define PMR_RST_SETUP 8'h00
`define PMR_SLAVE_ADDR 7'h40

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define PMR_MASK_VALID 16'hF506
`define PMR_BIT_VOUT_UV 15
`define PMR_BIT_OC_WARN 14
`define PMR_BIT_VIN_UV 13
`define PMR_BIT_VIN_OV 12
`define PMR_BIT_OT_WARN 10
`define PMR_BIT_OP_WARN 8
`define PMR_BIT_OT_FAULT 2
`define PMR_BIT_CML 1
`define PMR_SETUP_VALID 8'h14
`define PMR_SETUP_GAIN 4
`define PMR_SETUP_SRC 2
`define PMR_STIN_OC 1
`define PMR_STIN_OP 0

`endif

// ===== rtl/pmr_mfr_regs.v
// manufacturer command registers of the power monitor, SMBus slave side
//
// Functional notes
// - aux reading saturates at 0FFFh when input at or above full scale.
// - aux reading returns 0000h when input at or below ground.
// - aux voltage is a 12-bit word read at D0h, zero after reset.
// - input current is a 12-bit word read at D1h, zero after reset.
// - input power at D2h is upper 12 bits of voltage times current.
// - current above D3h limit sets over-current flags and asserts alert.
// - current limit 0FFFh disables the warning and is the reset value.
// - power above D4h limit sets over-power flags and asserts alert.
// - power limit 0FFFh disables the warning and is the reset value.
// - D5h keeps the largest power since reset or clear, from zero.
// - send byte D6h from host clears the stored peak power.
// - each set bit of mask D8h suppresses alert for its condition.
// - masked conditions are still recorded in the status flags.
// - mask bits 15,14,13,12,10,8,2,1 defined; others read zero.
// - mask is read and written as a word, resets all clear.
// - setup bit 4 picks gain: zero high range, one low range.
// - setup bit 2 zero uses strapped gain pin, one uses bit 4.
// - setup is a byte at D9h; bits 7:5, 3, 1, 0 read zero.
// - changing gain source does not restart telemetry averaging.
// - input status bit 1 is over-current, bit 0 over-power.
// - latched flags clear only if condition gone and clear-faults seen.
`timescale 1ns/100ps
`include "pmr_defines.vh"

module pmr_mfr_regs #(
  parameter [6:0] SLAVE_ADDR = `PMR_SLAVE_ADDR
) (
  input wire mclk,
  input wire sys_rst,
  input wire scl_in,
  input wire sda_in,
  output reg sda_out,
  output reg sda_oe,
  input wire gain_pin,
  input wire smp_valid,
  input wire [11:0] vin_smp,
  input wire [11:0] iin_smp,
  input wire signed [12:0] aux_smp,
  input wire vout_uv_warn,
  input wire vin_uv_warn,
  input wire vin_ov_warn,
  input wire ot_warn,
  input wire ot_fault,
  output reg alert_n,
  output reg gain_low,
  output reg [1:0] status_input_warn,
  output reg [15:0] cond_latched
);

  // ----------------------------------------------------------------
  // bus states
  // ----------------------------------------------------------------
  localparam [2:0] ST_IDLE = 3'd0;
  localparam [2:0] ST_RX = 3'd1;
  localparam [2:0] ST_RACK = 3'd2;
  localparam [2:0] ST_TX = 3'd3;
  localparam [2:0] ST_TACK = 3'd4;
  localparam [2:0] ST_WAIT = 3'd5;

  reg [2:0] scl_s;
  reg [2:0] sda_s;
  reg [2:0] gpin_s;
  reg scl_f;
  reg sda_f;
  reg gpin_f;
  reg [2:0] state;
  reg [3:0] bitcnt;
  reg [2:0] byte_idx;
  reg [7:0] rx_sh;
  reg [7:0] tx_sh;
  reg [7:0] tx_next;
  reg rd_mode;
  reg [7:0] cmd;
  reg [7:0] data_lo;
  reg [7:0] data_hi;
  reg cml_ev;
  reg [11:0] aux_volt;
  reg [11:0] in_curr;
  reg [11:0] in_power;
  reg [11:0] peak_power;
  reg [11:0] oc_limit;
  reg [11:0] op_limit;
  reg [15:0] alert_mask;
  reg [7:0] gain_setup;
  reg [15:0] cond_now;
  reg [15:0] rd_word;
  wire scl_nx;
  wire sda_nx;
  wire scl_rise;
  wire scl_fall;
  wire start_ev;
  wire stop_ev;
  wire cmd_ok;
  wire addr_hit;
  wire clr_faults;
  wire clr_peak;
  wire wr_word;
  wire wr_byte;
  wire [23:0] product;
  wire [11:0] power_new;
  wire [11:0] aux_clamped;

  // ----------------------------------------------------------------
  // pin sampling
  // ----------------------------------------------------------------
  // three-stage sync; level accepted once stages two and three agree
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      scl_s <= 3'h7;
      sda_s <= 3'h7;
      gpin_s <= 3'h0;
      scl_f <= 1'b1;
      sda_f <= 1'b1;
      gpin_f <= 1'b0;
    end else begin
      scl_s <= {scl_s[1:0], scl_in};
      sda_s <= {sda_s[1:0], sda_in};
      gpin_s <= {gpin_s[1:0], gain_pin};
      scl_f <= scl_nx;
      sda_f <= sda_nx;
      if (gpin_s[1] == gpin_s[2]) begin
        gpin_f <= gpin_s[2];
      end
    end
  end

  assign scl_nx = (scl_s[1] == scl_s[2]) ? scl_s[2] : scl_f;
  assign sda_nx = (sda_s[1] == sda_s[2]) ? sda_s[2] : sda_f;
  assign scl_rise = ~scl_f & scl_nx;
  assign scl_fall = scl_f & ~scl_nx;
  assign start_ev = scl_f & scl_nx & sda_f & ~sda_nx;
  assign stop_ev = scl_f & scl_nx & ~sda_f & sda_nx;

  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  assign addr_hit = (rx_sh[7:1] == SLAVE_ADDR);
  assign cmd_ok = (rx_sh == `PMR_CMD_CLEAR_FAULTS) ||
                  ((rx_sh >= `PMR_CMD_AUX_VOLT) &&
                   (rx_sh <= `PMR_CMD_PEAK_CLEAR)) ||
                  (rx_sh == `PMR_CMD_ALERT_MASK) ||
                  (rx_sh == `PMR_CMD_GAIN_SETUP);
  // writes take effect at stop, by count of acked bytes
  assign clr_faults = stop_ev & ~rd_mode & (byte_idx == 3'd2) &
                      (cmd == `PMR_CMD_CLEAR_FAULTS);
  assign clr_peak = stop_ev & ~rd_mode & (byte_idx == 3'd2) &
                    (cmd == `PMR_CMD_PEAK_CLEAR);
  assign wr_byte = stop_ev & ~rd_mode & (byte_idx == 3'd3);
  assign wr_word = stop_ev & ~rd_mode & (byte_idx == 3'd4);

  // read data by command, low byte goes first
  always @* begin
    case (cmd)
      `PMR_CMD_AUX_VOLT: rd_word = {4'h0, aux_volt};
      `PMR_CMD_IN_CURR: rd_word = {4'h0, in_curr};
      `PMR_CMD_IN_POWER: rd_word = {4'h0, in_power};
      `PMR_CMD_OC_LIMIT: rd_word = {4'h0, oc_limit};
      `PMR_CMD_OP_LIMIT: rd_word = {4'h0, op_limit};
      `PMR_CMD_PEAK_POWER: rd_word = {4'h0, peak_power};
      `PMR_CMD_ALERT_MASK: rd_word = alert_mask;
      `PMR_CMD_GAIN_SETUP: rd_word = {8'h00, gain_setup};
      default: rd_word = 16'hFFFF;
    endcase
  end

  // ----------------------------------------------------------------
  // bus state machine
  // ----------------------------------------------------------------
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= ST_IDLE;
      bitcnt <= 4'h0;
      byte_idx <= 3'd0;
      rx_sh <= 8'h00;
      tx_sh <= 8'hFF;
      tx_next <= 8'hFF;
      rd_mode <= 1'b0;
      cmd <= 8'h00;
      data_lo <= 8'h00;
      data_hi <= 8'h00;
      sda_oe <= 1'b0;
      sda_out <= 1'b0;
      cml_ev <= 1'b0;
    end else begin
      cml_ev <= 1'b0;
      if (start_ev) begin
        state <= ST_RX;
        bitcnt <= 4'h0;
        byte_idx <= 3'd0;
        rd_mode <= 1'b0;
        sda_oe <= 1'b0;
      end else if (stop_ev) begin
        state <= ST_IDLE;
        sda_oe <= 1'b0;
      end else begin
        case (state)
          ST_RX: begin
            if (scl_rise) begin
              rx_sh <= {rx_sh[6:0], sda_f};
              bitcnt <= bitcnt + 4'h1;
            end else if (scl_fall && bitcnt == 4'h8) begin
              if (byte_idx == 3'd0) begin
                if (addr_hit) begin
                  rd_mode <= rx_sh[0];
                  sda_oe <= 1'b1;
                  state <= ST_RACK;
                end else begin
                  state <= ST_WAIT;
                end
              end else if (byte_idx == 3'd1) begin
                if (cmd_ok) begin
                  cmd <= rx_sh;
                  sda_oe <= 1'b1;
                  state <= ST_RACK;
                end else begin
                  cml_ev <= 1'b1;
                  state <= ST_WAIT;
                end
              end else if (byte_idx < 3'd4) begin
                if (byte_idx == 3'd2) begin
                  data_lo <= rx_sh;
                end else begin
                  data_hi <= rx_sh;
                end
                sda_oe <= 1'b1;
                state <= ST_RACK;
              end else begin
                cml_ev <= 1'b1;
                state <= ST_WAIT;
              end
            end
          end
          ST_RACK: begin
            if (scl_fall) begin
              bitcnt <= 4'h0;
              byte_idx <= byte_idx + 3'd1;
              if (rd_mode) begin
                sda_oe <= ~rd_word[7];
                tx_sh <= {rd_word[6:0], 1'b0};
                tx_next <= rd_word[15:8];
                state <= ST_TX;
              end else begin
                sda_oe <= 1'b0;
                state <= ST_RX;
              end
            end
          end
          ST_TX: begin
            if (scl_rise) begin
              bitcnt <= bitcnt + 4'h1;
            end else if (scl_fall) begin
              if (bitcnt == 4'h8) begin
                sda_oe <= 1'b0;
                state <= ST_TACK;
              end else begin
                sda_oe <= ~tx_sh[7];
                tx_sh <= {tx_sh[6:0], 1'b0};
              end
            end
          end
          ST_TACK: begin
            if (scl_rise) begin
              if (sda_f) begin
                state <= ST_WAIT;
              end else begin
                tx_sh <= tx_next;
                tx_next <= 8'hFF;
                bitcnt <= 4'h0;
                state <= ST_TX;
              end
            end
          end
          ST_WAIT: sda_oe <= 1'b0;
          default: state <= ST_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // telemetry
  // ----------------------------------------------------------------
  // clamp negative input to zero
  assign aux_clamped = aux_smp[12] ? 12'h000 : aux_smp[11:0];
  assign product = vin_smp * iin_smp;
  assign power_new = product[23:12];

  // gain source change touches no sample state
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      aux_volt <= `PMR_RST_READING;
      in_curr <= `PMR_RST_READING;
      in_power <= `PMR_RST_READING;
      peak_power <= `PMR_RST_READING;
    end else begin
      if (smp_valid) begin
        aux_volt <= aux_clamped;
        in_curr <= iin_smp;
        in_power <= power_new;
      end
      if (smp_valid && (clr_peak || power_new > peak_power)) begin
        peak_power <= power_new;
      end else if (clr_peak) begin
        peak_power <= `PMR_RST_READING;
      end
    end
  end

  // ----------------------------------------------------------------
  // host-written registers
  // ----------------------------------------------------------------
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      oc_limit <= `PMR_RST_LIMIT;
      op_limit <= `PMR_RST_LIMIT;
      alert_mask <= `PMR_RST_MASK;
      gain_setup <= `PMR_RST_SETUP;
    end else begin
      if (wr_word && cmd == `PMR_CMD_OC_LIMIT) begin
        oc_limit <= {data_hi[3:0], data_lo};
      end
      if (wr_word && cmd == `PMR_CMD_OP_LIMIT) begin
        op_limit <= {data_hi[3:0], data_lo};
      end
      if (wr_word && cmd == `PMR_CMD_ALERT_MASK) begin
        alert_mask <= {data_hi, data_lo} & `PMR_MASK_VALID;
      end
      if (wr_byte && cmd == `PMR_CMD_GAIN_SETUP) begin
        gain_setup <= data_lo & `PMR_SETUP_VALID;
      end
    end
  end

  // ----------------------------------------------------------------
  // warning conditions
  // ----------------------------------------------------------------
  always @* begin
    cond_now = 16'h0000;
    cond_now[`PMR_BIT_VOUT_UV] = vout_uv_warn;
    cond_now[`PMR_BIT_VIN_UV] = vin_uv_warn;
    cond_now[`PMR_BIT_VIN_OV] = vin_ov_warn;
    cond_now[`PMR_BIT_OT_WARN] = ot_warn;
    cond_now[`PMR_BIT_OT_FAULT] = ot_fault;
    cond_now[`PMR_BIT_CML] = cml_ev;
    cond_now[`PMR_BIT_OC_WARN] = smp_valid &
      (oc_limit != `PMR_LIMIT_OFF) & (iin_smp > oc_limit);
    cond_now[`PMR_BIT_OP_WARN] = smp_valid &
      (op_limit != `PMR_LIMIT_OFF) & (power_new > op_limit);
  end

  // per-bit latch, a new event wins over a clear
  localparam [15:0] LATCH_OK = `PMR_MASK_VALID;
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi = gi + 1) begin : g_latch
      always @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
          cond_latched[gi] <= 1'b0;
        end else if (cond_now[gi] && LATCH_OK[gi]) begin
          cond_latched[gi] <= 1'b1;
        end else if (clr_faults) begin
          cond_latched[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      alert_n <= 1'b1;
      gain_low <= 1'b0;
      status_input_warn <= 2'b00;
    end else begin
      alert_n <= ~|(cond_latched & ~alert_mask);
      gain_low <= gain_setup[`PMR_SETUP_SRC] ?
                  gain_setup[`PMR_SETUP_GAIN] : gpin_f;
      status_input_warn[`PMR_STIN_OC] <= cond_latched[`PMR_BIT_OC_WARN];
      status_input_warn[`PMR_STIN_OP] <= cond_latched[`PMR_BIT_OP_WARN];
    end
  end

endmodule // pmr_mfr_regs

// ===== tb/pmr_mfr_regs_monitor.sv
// checker for the manufacturer command register block
`timescale 1ns/100ps
`include "pmr_defines.vh"
module pmr_mfr_regs_monitor (
  input wire mclk,
  input wire sys_rst,
  input wire vout_uv_warn,
  input wire vin_uv_warn,
  input wire ot_fault,
  input wire alert_n,
  input wire [1:0] status_input_warn,
  input wire [15:0] cond_latched
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // ------------------------------------------------
  // latches, status and alert
  // ------------------------------------------------
  uv_out_latch_a: assert property (vout_uv_warn |=> cond_latched[15])
    else $error("vout uv not latched");
  uv_in_latch_a: assert property (vin_uv_warn |=> cond_latched[13])
    else $error("vin uv not latched");
  ot_fault_latch_a: assert property (ot_fault |=> cond_latched[2])
    else $error("ot fault not latched");
  oc_status_a: assert property ($rose(status_input_warn[1]) |->
    $past(cond_latched[14])) else $error("oc flag without latch");
  op_status_a: assert property ($rose(status_input_warn[0]) |->
    $past(cond_latched[8])) else $error("op flag without latch");
  rsvd_zero_a: assert property ((cond_latched & ~`PMR_MASK_VALID) == 0)
    else $error("reserved latch set");
  alert_idle_a: assert property (cond_latched == 16'h0000 &&
    $past(cond_latched) == 16'h0000 |-> alert_n) else $error("stray alert");
  alert_cause_a: assert property ($fell(alert_n) |->
    (cond_latched | $past(cond_latched)) != 16'h0000)
    else $error("alert without latch");
  // main scenarios reached
  cover property ($fell(alert_n));
  cover property ($rose(status_input_warn[1]));
  cover property ($rose(cond_latched[1]));
endmodule // pmr_mfr_regs_monitor

bind pmr_mfr_regs pmr_mfr_regs_monitor pmr_mfr_regs_monitor_i (
  .mclk(mclk), .sys_rst(sys_rst), .vout_uv_warn(vout_uv_warn),
  .vin_uv_warn(vin_uv_warn), .ot_fault(ot_fault), .alert_n(alert_n),
  .status_input_warn(status_input_warn), .cond_latched(cond_latched));

// ===== tb/pmr_host_model.sv
// smbus host model driving clock and data toward the device
`timescale 1ns/100ps
module pmr_host_model (
  input wire mclk,
  input wire sda_oe,
  output reg scl,
  output wire sda
);
  reg pull;
  // open-drain data wire with pull-up
  assign sda = ~(pull | sda_oe);
  initial begin
    scl = 1'b1;
    pull = 1'b0;
  end
  // quarter of a 160 ns bit
  task q;
    repeat (10) @(negedge mclk);
  endtask
  // start or repeated start
  task start;
    pull = 1'b0;
    q;
    scl = 1'b1;
    q;
    pull = 1'b1;
    q;
    scl = 1'b0;
    q;
  endtask
  // stop, clock left standing high
  task stop;
    pull = 1'b1;
    q;
    scl = 1'b1;
    q;
    pull = 1'b0;
    q;
  endtask
  // one bit, data held across the high phase
  task bit_(input b, output r);
    pull = ~b;
    q;
    scl = 1'b1;
    q;
    r = sda;
    q;
    scl = 1'b0;
    q;
  endtask
  // byte msb first, then ninth bit
  task xbyte(input [7:0] d, input h, output [7:0] r, output ack);
    integer i;
    reg b;
    for (i = 7; i >= 0; i = i - 1) begin
      bit_(d[i], b);
      r[i] = b;
    end
    bit_(h, b);
    ack = ~b;
  endtask
endmodule // pmr_host_model

// ===== tb/pmr_mfr_regs_bench.sv
// self-checking bench for the manufacturer command registers
`timescale 1ns/100ps
`include "pmr_defines.vh"
module pmr_mfr_regs_bench;
  reg mclk = 1'b0;
  reg sys_rst = 1'b1;
  reg gain_pin = 1'b0;
  reg smp_valid = 1'b0;
  reg [11:0] vin_smp = 12'h000;
  reg [11:0] iin_smp = 12'h000;
  reg signed [12:0] aux_smp = 13'h0;
  reg [4:0] warns = 5'h00;
  wire scl, sda, sda_out, sda_oe, alert_n, gain_low;
  wire [1:0] st;
  wire [15:0] cond;
  integer num_errors = 0;
  integer tests_run = 0;
  reg [31:0] seed = 32'hD9DF6FE2;
  reg [15:0] rv;
  reg [11:0] pk, lim, p;
  reg [12:0] a;
  reg [7:0] rb, c;
  reg ack, lack;
  integer i;
  localparam [7:0] ADW = {`PMR_SLAVE_ADDR, 1'b0};
  always #2 mclk = ~mclk;
  pmr_host_model pmr_host_model_i (.mclk(mclk), .sda_oe(sda_oe),
    .scl(scl), .sda(sda));
  pmr_mfr_regs pmr_mfr_regs_i (.mclk(mclk), .sys_rst(sys_rst),
    .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .gain_pin(gain_pin), .smp_valid(smp_valid), .vin_smp(vin_smp),
    .iin_smp(iin_smp), .aux_smp(aux_smp), .vout_uv_warn(warns[4]),
    .vin_uv_warn(warns[3]), .vin_ov_warn(warns[2]), .ot_warn(warns[1]),
    .ot_fault(warns[0]), .alert_n(alert_n), .gain_low(gain_low),
    .status_input_warn(st), .cond_latched(cond));
  // ------------------------------------------------
  // helpers
  // ------------------------------------------------
  function [31:0] xs(input [31:0] x);
    reg [31:0] y;
    begin
      y = x ^ (x << 13);
      y = y ^ (y >> 17);
      xs = y ^ (y << 5);
    end
  endfunction
  function [11:0] pw(input [11:0] v, input [11:0] k);
    reg [23:0] m;
    begin
      m = v * k;
      pw = m[23:12];
    end
  endfunction
  function [11:0] ax(input [12:0] s);
    ax = s[12] ? 12'h000 : s[11:0];
  endfunction
  task close_out;
    if (num_errors == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task chk(input [15:0] seen, input [15:0] exp, input string nm);
    tests_run = tests_run + 1;
    if (seen !== exp) begin
      num_errors = num_errors + 1;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  // write with n data bytes, low byte first
  task wr(input [7:0] k, input [15:0] d, input integer n);
    pmr_host_model_i.start;
    pmr_host_model_i.xbyte(ADW, 1'b1, rb, ack);
    pmr_host_model_i.xbyte(k, 1'b1, rb, lack);
    if (n > 0) pmr_host_model_i.xbyte(d[7:0], 1'b1, rb, ack);
    if (n > 1) pmr_host_model_i.xbyte(d[15:8], 1'b1, rb, ack);
    pmr_host_model_i.stop;
    repeat (4) @(negedge mclk);
  endtask
  // read n bytes through a repeated start, then compare
  task rchk(input [7:0] k, input integer n, input [15:0] e, input string nm);
    rv = 16'h0000;
    pmr_host_model_i.start;
    pmr_host_model_i.xbyte(ADW, 1'b1, rb, ack);
    pmr_host_model_i.xbyte(k, 1'b1, rb, ack);
    pmr_host_model_i.start;
    pmr_host_model_i.xbyte(ADW | 8'h01, 1'b1, rb, ack);
    pmr_host_model_i.xbyte(8'hFF, n == 1, rv[7:0], ack);
    if (n > 1) pmr_host_model_i.xbyte(8'hFF, 1'b1, rv[15:8], ack);
    pmr_host_model_i.stop;
    repeat (4) @(negedge mclk);
    chk(rv, e, nm);
  endtask
  task smp(input [11:0] v, input [11:0] k, input [12:0] s);
    @(negedge mclk);
    vin_smp = v;
    iin_smp = k;
    aux_smp = s;
    smp_valid = 1'b1;
    @(negedge mclk);
    smp_valid = 1'b0;
    repeat (3) @(negedge mclk);
  endtask
  // ------------------------------------------------
  // main sequence
  // ------------------------------------------------
  initial begin
    repeat (12) @(negedge mclk);
    sys_rst = 1'b0;
    repeat (4) @(negedge mclk);
    for (i = 0; i < 6; i = i + 1) begin
      c = 8'hD0 + i[7:0];
      rchk(c, 2, (i == 3 || i == 4) ? 16'h0FFF : 16'h0000, "rst");
    end
    rchk(`PMR_CMD_ALERT_MASK, 2, 16'h0000, "mask rst");
    rchk(`PMR_CMD_GAIN_SETUP, 1, 16'h0000, "setup rst");
    chk(sda_out, 16'h0000, "sda out");
    wr(`PMR_CMD_OC_LIMIT, 16'hFFFF, 2);
    rchk(`PMR_CMD_OC_LIMIT, 2, 16'h0FFF, "oc lim");
    wr(`PMR_CMD_ALERT_MASK, 16'hFFFF, 2);
    rchk(`PMR_CMD_ALERT_MASK, 2, 16'hF506, "mask");
    wr(`PMR_CMD_GAIN_SETUP, 16'h00FF, 1);
    rchk(`PMR_CMD_GAIN_SETUP, 1, 16'h0014, "setup");
    wr(`PMR_CMD_PEAK_POWER, 16'h1234, 2);
    rchk(`PMR_CMD_PEAK_POWER, 2, 16'h0000, "peak ro");
    // gain source against strap pin
    for (i = 0; i < 4; i = i + 1) begin
      gain_pin = i[0];
      wr(`PMR_CMD_GAIN_SETUP, {11'h0, ~i[0], 1'b0, i[1], 2'b00}, 1);
      repeat (8) @(negedge mclk);
      chk(gain_low, {15'h0000, i[1] ^ i[0]}, "gain");
    end
    // telemetry with warnings disabled
    pk = 12'h000;
    for (i = 0; i < 3; i = i + 1) begin
      seed = xs(seed);
      a = (i == 0) ? 13'h1FFF : (i == 1) ? 13'h0FFF : seed[28:16];
      p = pw(seed[11:0], seed[23:12]);
      if (p > pk) pk = p;
      smp(seed[11:0], seed[23:12], a);
      rchk(`PMR_CMD_AUX_VOLT, 2, {4'h0, ax(a)}, "aux");
      rchk(`PMR_CMD_IN_CURR, 2, {4'h0, seed[23:12]}, "iin");
      rchk(`PMR_CMD_IN_POWER, 2, {4'h0, p}, "pin");
      chk(st, 16'h0000, "off");
    end
    rchk(`PMR_CMD_PEAK_POWER, 2, {4'h0, pk}, "peak");
    wr(`PMR_CMD_PEAK_CLEAR, 16'h0000, 0);
    rchk(`PMR_CMD_PEAK_POWER, 2, 16'h0000, "peak clr");
    smp(12'h100, 12'h100, 13'h0);
    smp(12'h080, 12'h100, 13'h0);
    rchk(`PMR_CMD_PEAK_POWER, 2, 16'h0010, "peak new");
    // over-current and over-power while masked
    seed = xs(seed);
    lim = {1'b0, seed[10:0]};
    wr(`PMR_CMD_OC_LIMIT, {4'h0, lim}, 2);
    smp(12'h001, lim, 13'h0);
    chk(st, 16'h0000, "at lim");
    smp(12'h001, lim + 12'h001, 13'h0);
    chk(st, 16'h0002, "oc");
    chk(alert_n, 16'h0001, "masked");
    wr(`PMR_CMD_OP_LIMIT, 16'h0000, 2);
    smp(12'hFFF, 12'hFFF, 13'h0);
    chk(st, 16'h0003, "op");
    @(negedge mclk);
    warns = 5'h1F;
    @(negedge mclk);
    warns = 5'h00;
    repeat (3) @(negedge mclk);
    chk(cond, 16'hF504, "conds");
    chk(alert_n, 16'h0001, "all masked");
    wr(`PMR_CMD_ALERT_MASK, 16'h0000, 2);
    chk(alert_n, 16'h0000, "unmasked");
    wr(`PMR_CMD_CLEAR_FAULTS, 16'h0000, 0);
    chk(st, 16'h0000, "cleared");
    chk(alert_n, 16'h0001, "alert off");
    // unsupported command code
    wr(8'hD7, 16'h0000, 0);
    chk(lack, 16'h0000, "nack");
    chk(cond, 16'h0002, "cml");
    chk(alert_n, 16'h0000, "cml alert");
    close_out;
  end
  // hang guard
  initial begin
    repeat (95000) @(posedge mclk);
    num_errors = num_errors + 1;
    close_out;
  end
endmodule // pmr_mfr_regs_bench
